// [logic/diag_pkg.sv]
// Purpose: shared constants for the diagnostic control registers
// Assumes: byte-wide registers on a plain address/strobe port
// Notes:   offsets are register addresses on that port
package diag_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int CRC_W  = 16;
	localparam int IRQ_W  = 3;

	// ************************************************************
	// register offsets
	// ************************************************************
	localparam logic [ADDR_W-1:0] OTP_DIAG_CONTROL_ADDR        = 16'h0335;
	localparam logic [ADDR_W-1:0] COMM_DIAG_CONTROL_ADDR       = 16'h0336;
	localparam logic [ADDR_W-1:0] SUPPLY_SELFTEST_CONTROL_ADDR = 16'h0337;
	localparam logic [ADDR_W-1:0] EVENT_STATUS_ADDR            = 16'h03F0;
	localparam logic [ADDR_W-1:0] EVENT_CLEAR_ADDR             = 16'h03F1;
	localparam logic [ADDR_W-1:0] EVENT_ENABLE_ADDR            = 16'h03F2;
	localparam logic [ADDR_W-1:0] SUPPLY_FAULT_A_ADDR          = 16'h03F3;
	localparam logic [ADDR_W-1:0] SUPPLY_FAULT_B_ADDR          = 16'h03F4;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int MARGIN_GO_BIT          = 0;
	localparam int MARGIN_MODE_LSB        = 1;
	localparam int MARGIN_MODE_W          = 3;
	localparam int FACTORY_CRC_INVERT_BIT = 4;
	localparam int RESPONSE_CRC_INVERT_BIT = 0;
	localparam int LOOP_ENABLE_BIT        = 1;
	localparam int SELFTEST_START_BIT     = 0;
	localparam int KEEP_FAULTS_BIT        = 1;
	localparam int EV_SELFTEST_DONE_BIT   = 0;
	localparam int EV_FACTORY_CRC_BIT     = 1;
	localparam int EV_SUPPLY_FAULT_BIT    = 2;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [DATA_W-1:0] OTP_DIAG_RESET    = 8'h00;
	localparam logic [DATA_W-1:0] COMM_DIAG_RESET   = 8'h00;
	localparam logic [DATA_W-1:0] SUPPLY_DIAG_RESET = 8'h00;
	localparam logic [DATA_W-1:0] ZERO_BYTE         = 8'h00;
	localparam logic [IRQ_W-1:0]  IRQ_RESET         = 3'h0;
	localparam logic [CRC_W-1:0]  CRC_RESET         = 16'h0000;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_RUN    = 2'b01,
		ST_FINISH = 2'b11
	} selftest_state_type;
endpackage : diag_pkg

// [logic/selftest_seq.sv]
// Purpose: power-supply self-test sequencer
// Assumes: i_done comes from the comparator side while running
// Notes:   keep option is sampled only at start
`timescale 1ns/100ps
`default_nettype none
module selftest_seq (
	input  wire logic i_ref_clk,
	input  wire logic i_rst,
	input  wire logic i_clk_en,
	input  wire logic i_start,
	input  wire logic i_keep_faults,
	input  wire logic i_done,
	output logic      o_running,
	output logic      o_finish,
	output logic      o_keep_faults
);
	import diag_pkg::*;

	selftest_state_type state;
	selftest_state_type next_state;
	logic               keep;
	logic               next_keep;

	always_comb begin
		next_state = state;
		next_keep  = keep;
		unique case (state)
			ST_IDLE: begin
				if (i_start) begin
					next_keep  = i_keep_faults;
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (i_done) begin
					next_state = ST_FINISH;
				end
			end
			ST_FINISH: begin
				next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			state <= ST_IDLE;
			keep  <= 1'b0;
		end else if (i_clk_en) begin
			state <= next_state;
			keep  <= next_keep;
		end
	end

	assign o_running     = (state == ST_RUN);
	assign o_finish      = (state == ST_FINISH);
	assign o_keep_faults = keep;
endmodule : selftest_seq
`default_nettype wire

// [logic/diagnostic_control_regs.sv]
// Purpose: diagnostic control registers of the battery monitor
// Assumes: single clock, inputs synchronous, one strobe per cycle
// Notes:   read data stand one cycle after the read strobe
//
// Chosen here: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module diagnostic_control_regs (
	input  wire logic                          i_ref_clk,
	input  wire logic                          i_rst,
	input  wire logic                          i_clk_en,
	input  wire logic [diag_pkg::ADDR_W-1:0]   i_addr,
	input  wire logic [diag_pkg::DATA_W-1:0]   i_wdata,
	input  wire logic                          i_wr,
	input  wire logic                          i_rd,
	output logic      [diag_pkg::DATA_W-1:0]   o_rdata,
	input  wire logic [diag_pkg::CRC_W-1:0]    i_factory_crc_stored,
	input  wire logic [diag_pkg::CRC_W-1:0]    i_factory_crc_calc,
	output logic      [diag_pkg::CRC_W-1:0]    o_factory_crc,
	output logic                               o_factory_crc_fault,
	output logic      [diag_pkg::MARGIN_MODE_W-1:0] o_margin_mode,
	output logic                               o_margin_start,
	input  wire logic [diag_pkg::CRC_W-1:0]    i_resp_crc,
	output logic      [diag_pkg::CRC_W-1:0]    o_resp_crc,
	output logic                               o_serial_master_loop_enable,
	input  wire logic                          i_selftest_done,
	input  wire logic [diag_pkg::DATA_W-1:0]   i_supply_fault_a_set,
	input  wire logic [diag_pkg::DATA_W-1:0]   i_supply_fault_b_set,
	output logic                               o_selftest_running,
	output logic                               o_fault_out_n,
	output logic                               o_irq
);
	import diag_pkg::*;

	// ************************************************************
	// state
	// ************************************************************
	logic [DATA_W-1:0] otp_diag_control;
	logic [DATA_W-1:0] next_otp_diag_control;
	logic [DATA_W-1:0] comm_diag_control;
	logic [DATA_W-1:0] next_comm_diag_control;
	logic [DATA_W-1:0] supply_selftest_control;
	logic [DATA_W-1:0] next_supply_selftest_control;
	logic [DATA_W-1:0] supply_fault_status_a;
	logic [DATA_W-1:0] next_supply_fault_status_a;
	logic [DATA_W-1:0] supply_fault_status_b;
	logic [DATA_W-1:0] next_supply_fault_status_b;
	logic [IRQ_W-1:0]  event_status;
	logic [IRQ_W-1:0]  next_event_status;
	logic [IRQ_W-1:0]  event_enable;
	logic [IRQ_W-1:0]  next_event_enable;
	logic [DATA_W-1:0] rdata;
	logic [DATA_W-1:0] next_rdata;
	logic              margin_start;
	logic              next_margin_start;
	logic              selftest_start;
	logic              next_selftest_start;
	logic [CRC_W-1:0]  factory_crc;
	logic [CRC_W-1:0]  next_factory_crc;
	logic              factory_fault;
	logic              next_factory_fault;
	logic [CRC_W-1:0]  resp_crc;
	logic [CRC_W-1:0]  next_resp_crc;

	logic              st_finish;
	logic              st_keep;
	logic              st_running;
	logic [IRQ_W-1:0]  events;

	// ************************************************************
	// helpers
	// ************************************************************
	function automatic logic is_write(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] o);
		return i_wr && (a == o);
	endfunction : is_write

	function automatic logic [CRC_W-1:0] crc_flip(input logic [CRC_W-1:0] c, input logic inv);
		return inv ? ~c : c;
	endfunction : crc_flip

	// ************************************************************
	// self-test sequencer
	// ************************************************************
	selftest_seq u_selftest_seq (
		.i_ref_clk     (i_ref_clk),
		.i_rst         (i_rst),
		.i_clk_en      (i_clk_en),
		.i_start       (selftest_start),
		.i_keep_faults (supply_selftest_control[KEEP_FAULTS_BIT]),
		.i_done        (i_selftest_done),
		.o_running     (st_running),
		.o_finish      (st_finish),
		.o_keep_faults (st_keep)
	);

	// ************************************************************
	// control registers
	// ************************************************************
	always_comb begin
		next_otp_diag_control        = otp_diag_control;
		next_comm_diag_control       = comm_diag_control;
		next_supply_selftest_control = supply_selftest_control;
		next_event_enable            = event_enable;
		next_margin_start            = 1'b0;
		next_selftest_start          = 1'b0;
		if (is_write(i_addr, OTP_DIAG_CONTROL_ADDR)) begin
			// go bit is never stored, so it always reads zero
			next_otp_diag_control = {3'h0, i_wdata[4:1], 1'b0};
			next_margin_start     = i_wdata[MARGIN_GO_BIT];
		end
		if (is_write(i_addr, COMM_DIAG_CONTROL_ADDR)) begin
			next_comm_diag_control = {6'h00, i_wdata[1:0]};
		end
		if (is_write(i_addr, SUPPLY_SELFTEST_CONTROL_ADDR)) begin
			next_supply_selftest_control = {6'h00, i_wdata[KEEP_FAULTS_BIT], 1'b0};
			next_selftest_start          = i_wdata[SELFTEST_START_BIT];
		end
		if (is_write(i_addr, EVENT_ENABLE_ADDR)) begin
			next_event_enable = i_wdata[IRQ_W-1:0];
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			otp_diag_control        <= OTP_DIAG_RESET;
			comm_diag_control       <= COMM_DIAG_RESET;
			supply_selftest_control <= SUPPLY_DIAG_RESET;
			event_enable            <= IRQ_RESET;
			margin_start            <= 1'b0;
			selftest_start          <= 1'b0;
		end else if (i_clk_en) begin
			otp_diag_control        <= next_otp_diag_control;
			comm_diag_control       <= next_comm_diag_control;
			supply_selftest_control <= next_supply_selftest_control;
			event_enable            <= next_event_enable;
			margin_start            <= next_margin_start;
			selftest_start          <= next_selftest_start;
		end
	end

	// ************************************************************
	// crc paths
	// ************************************************************
	always_comb begin
		next_factory_crc   = crc_flip(i_factory_crc_stored,
			otp_diag_control[FACTORY_CRC_INVERT_BIT]);
		// check runs on the flipped copy so the fault path is really exercised
		next_factory_fault = (next_factory_crc != i_factory_crc_calc);
		next_resp_crc      = crc_flip(i_resp_crc,
			comm_diag_control[RESPONSE_CRC_INVERT_BIT]);
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			factory_crc   <= CRC_RESET;
			factory_fault <= 1'b0;
			resp_crc      <= CRC_RESET;
		end else if (i_clk_en) begin
			factory_crc   <= next_factory_crc;
			factory_fault <= next_factory_fault;
			resp_crc      <= next_resp_crc;
		end
	end

	// ************************************************************
	// supply faults and events
	// ************************************************************
	assign events[EV_SELFTEST_DONE_BIT] = st_finish;
	assign events[EV_FACTORY_CRC_BIT]   = next_factory_fault && !factory_fault;
	assign events[EV_SUPPLY_FAULT_BIT]  = |{i_supply_fault_a_set, i_supply_fault_b_set};

	always_comb begin
		next_supply_fault_status_a = supply_fault_status_a;
		next_supply_fault_status_b = supply_fault_status_b;
		if (st_finish && !st_keep) begin
			next_supply_fault_status_a = ZERO_BYTE;
			next_supply_fault_status_b = ZERO_BYTE;
		end
		// a fault arriving with the clear still lands
		next_supply_fault_status_a = next_supply_fault_status_a | i_supply_fault_a_set;
		next_supply_fault_status_b = next_supply_fault_status_b | i_supply_fault_b_set;
		next_event_status = event_status;
		if (is_write(i_addr, EVENT_CLEAR_ADDR)) begin
			next_event_status = event_status & ~i_wdata[IRQ_W-1:0];
		end
		next_event_status = next_event_status | events;
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			supply_fault_status_a <= ZERO_BYTE;
			supply_fault_status_b <= ZERO_BYTE;
			event_status          <= IRQ_RESET;
		end else if (i_clk_en) begin
			supply_fault_status_a <= next_supply_fault_status_a;
			supply_fault_status_b <= next_supply_fault_status_b;
			event_status          <= next_event_status;
		end
	end

	// ************************************************************
	// read port
	// ************************************************************
	always_comb begin
		next_rdata = ZERO_BYTE;
		if (i_rd) begin
			unique case (i_addr)
				OTP_DIAG_CONTROL_ADDR:        next_rdata = otp_diag_control;
				COMM_DIAG_CONTROL_ADDR:       next_rdata = comm_diag_control;
				SUPPLY_SELFTEST_CONTROL_ADDR: next_rdata = supply_selftest_control;
				EVENT_STATUS_ADDR:            next_rdata = {5'h00, event_status};
				EVENT_ENABLE_ADDR:            next_rdata = {5'h00, event_enable};
				SUPPLY_FAULT_A_ADDR:          next_rdata = supply_fault_status_a;
				SUPPLY_FAULT_B_ADDR:          next_rdata = supply_fault_status_b;
				default:                      next_rdata = ZERO_BYTE;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			rdata <= ZERO_BYTE;
		end else if (i_clk_en) begin
			rdata <= next_rdata;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign o_rdata                     = rdata;
	assign o_factory_crc               = factory_crc;
	assign o_factory_crc_fault         = factory_fault;
	assign o_margin_mode               = otp_diag_control[MARGIN_MODE_LSB +: MARGIN_MODE_W];
	assign o_margin_start              = margin_start;
	assign o_resp_crc                  = resp_crc;
	assign o_serial_master_loop_enable = comm_diag_control[LOOP_ENABLE_BIT];
	assign o_selftest_running          = st_running;
	// fault line stays low while any held supply fault remains
	assign o_fault_out_n               = ~(|{supply_fault_status_a, supply_fault_status_b});
	assign o_irq                       = |(event_status & event_enable);
endmodule : diagnostic_control_regs
`default_nettype wire

// [sim/diagnostic_control_regs_properties.sv]
// Purpose: concurrent checks on the diagnostic control register ports
// Assumes: clock enable qualifies every strobe
// Notes:   invert and keep bits are shadowed from bus writes
`timescale 1ns/100ps
`default_nettype none
module diag_ctrl_checker (
	input wire logic                        i_ref_clk,
	input wire logic                        i_rst,
	input wire logic                        i_clk_en,
	input wire logic [diag_pkg::ADDR_W-1:0] i_addr,
	input wire logic [diag_pkg::DATA_W-1:0] i_wdata,
	input wire logic                        i_wr,
	input wire logic                        i_rd,
	input wire logic [diag_pkg::DATA_W-1:0] o_rdata,
	input wire logic [diag_pkg::CRC_W-1:0]  i_factory_crc_stored,
	input wire logic [diag_pkg::CRC_W-1:0]  i_factory_crc_calc,
	input wire logic [diag_pkg::CRC_W-1:0]  o_factory_crc,
	input wire logic                        o_factory_crc_fault,
	input wire logic                        o_margin_start,
	input wire logic [diag_pkg::CRC_W-1:0]  i_resp_crc,
	input wire logic [diag_pkg::CRC_W-1:0]  o_resp_crc,
	input wire logic                        i_selftest_done,
	input wire logic                        o_selftest_running,
	input wire logic                        o_fault_out_n
);
	import diag_pkg::*;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	logic             fflip, rflip, keep, armed, exp_fault, wr_otp, wr_comm, go;
	logic [CRC_W-1:0] exp_resp, exp_fcrc, fcrc;
	assign wr_otp = i_clk_en && i_wr && i_addr == OTP_DIAG_CONTROL_ADDR;
	assign wr_comm = i_clk_en && i_wr && i_addr == COMM_DIAG_CONTROL_ADDR;
	assign go = i_clk_en && i_wr && i_addr == SUPPLY_SELFTEST_CONTROL_ADDR && i_wdata[0]
		&& !o_selftest_running;
	assign fcrc = fflip ? ~i_factory_crc_stored : i_factory_crc_stored;
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			{fflip, rflip, keep, armed, exp_fault} <= 5'h00;
			exp_resp <= CRC_RESET;
			exp_fcrc <= CRC_RESET;
		end else begin
			armed <= i_clk_en;
			exp_resp <= rflip ? ~i_resp_crc : i_resp_crc;
			exp_fcrc <= fcrc;
			exp_fault <= fcrc != i_factory_crc_calc;
			if (wr_otp) fflip <= i_wdata[FACTORY_CRC_INVERT_BIT];
			if (wr_comm) rflip <= i_wdata[RESPONSE_CRC_INVERT_BIT];
			if (go) keep <= i_wdata[KEEP_FAULTS_BIT];
		end
	end
	sequence s_go;
		go;
	endsequence
	sequence s_end;
		$fell(o_selftest_running);
	endsequence
	property p_resp; armed |-> o_resp_crc == exp_resp; endproperty
	property p_fcrc; armed |-> o_factory_crc == exp_fcrc; endproperty
	property p_fault; armed |-> o_factory_crc_fault == exp_fault; endproperty
	property p_start; s_go |-> ##2 o_selftest_running; endproperty
	property p_hold; o_selftest_running && !i_selftest_done && i_clk_en |=> o_selftest_running;
	endproperty
	property p_goread; i_clk_en && i_rd && i_addr == SUPPLY_SELFTEST_CONTROL_ADDR
		|=> o_rdata[0] == 1'b0; endproperty
	property p_margin; wr_otp && i_wdata[0] |=> o_margin_start ##1 !o_margin_start; endproperty
	property p_clear; s_end ##0 !keep |=> o_fault_out_n; endproperty
	property p_keep; s_end ##0 (keep && !o_fault_out_n) |=> !o_fault_out_n; endproperty
	a_resp: assert property (p_resp) else $error("response crc wrong");
	a_fcrc: assert property (p_fcrc) else $error("factory crc wrong");
	a_fault: assert property (p_fault) else $error("factory fault wrong");
	a_start: assert property (p_start) else $error("self-test not started");
	a_hold: assert property (p_hold) else $error("self-test ended early");
	a_goread: assert property (p_goread) else $error("start bit reads one");
	a_margin: assert property (p_margin) else $error("margin start pulse wrong");
	a_clear: assert property (p_clear) else $error("faults not cleared");
	a_keep: assert property (p_keep) else $error("faults not kept");
endmodule : diag_ctrl_checker
bind diagnostic_control_regs diag_ctrl_checker i_chk (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
	.i_clk_en(i_clk_en), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
	.o_rdata(o_rdata), .i_factory_crc_stored(i_factory_crc_stored),
	.i_factory_crc_calc(i_factory_crc_calc), .o_factory_crc(o_factory_crc),
	.o_factory_crc_fault(o_factory_crc_fault), .o_margin_start(o_margin_start),
	.i_resp_crc(i_resp_crc), .o_resp_crc(o_resp_crc), .i_selftest_done(i_selftest_done),
	.o_selftest_running(o_selftest_running), .o_fault_out_n(o_fault_out_n));
`default_nettype wire

// [sim/diagnostic_control_regs_tb.sv]
// Purpose: self-checking bench for the diagnostic control registers
// Assumes: clock enable high apart from one frozen write
// Notes:   seeded random crc values, register data and fault patterns
`timescale 1ns/100ps
`default_nettype none
module diagnostic_control_regs_tb;
	import diag_pkg::*;
	logic                     i_ref_clk, i_rst, i_clk_en, i_wr, i_rd, i_selftest_done;
	logic                     o_factory_crc_fault, o_margin_start, o_serial_master_loop_enable;
	logic                     o_selftest_running, o_fault_out_n, o_irq;
	logic [ADDR_W-1:0]        i_addr;
	logic [DATA_W-1:0]        i_wdata, o_rdata, i_supply_fault_a_set, i_supply_fault_b_set, d;
	logic [CRC_W-1:0]         i_factory_crc_stored, i_factory_crc_calc, o_factory_crc;
	logic [CRC_W-1:0]         i_resp_crc, o_resp_crc, s;
	logic [MARGIN_MODE_W-1:0] o_margin_mode;
	int                       bad_count = 0;
	int                       compares = 0;
	int                       seed = 32'h01f7_b55f;
	diagnostic_control_regs i_diagnostic_control_regs (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
		.i_clk_en(i_clk_en), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_factory_crc_stored(i_factory_crc_stored),
		.i_factory_crc_calc(i_factory_crc_calc), .o_factory_crc(o_factory_crc),
		.o_factory_crc_fault(o_factory_crc_fault), .o_margin_mode(o_margin_mode),
		.o_margin_start(o_margin_start), .i_resp_crc(i_resp_crc), .o_resp_crc(o_resp_crc),
		.o_serial_master_loop_enable(o_serial_master_loop_enable),
		.i_selftest_done(i_selftest_done), .i_supply_fault_a_set(i_supply_fault_a_set),
		.i_supply_fault_b_set(i_supply_fault_b_set), .o_selftest_running(o_selftest_running),
		.o_fault_out_n(o_fault_out_n), .o_irq(o_irq));
	initial begin
		i_ref_clk = 1'b0;
		forever #2.5 i_ref_clk = ~i_ref_clk;
	end
	function automatic logic [CRC_W-1:0] flip_of(input logic f, input logic [CRC_W-1:0] v);
		return f ? ~v : v;
	endfunction : flip_of
	task automatic cmp(input logic [CRC_W-1:0] got, input logic [CRC_W-1:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic cmpb(input logic got, input logic exp);
		cmp({15'h0000, got}, {15'h0000, exp});
	endtask : cmpb
	task automatic tick(input int n);
		repeat (n) @(posedge i_ref_clk);
		#1;
	endtask : tick
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_wdata <= v;
		i_wr <= 1'b1;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		tick(1);
		i_rd <= 1'b0;
		cmp({8'h00, o_rdata}, {8'h00, exp});
	endtask : rd
	task automatic faults(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
		i_supply_fault_a_set <= a;
		i_supply_fault_b_set <= b;
		tick(1);
		{i_supply_fault_a_set, i_supply_fault_b_set} <= 16'h0000;
		tick(1);
		cmpb(o_fault_out_n, 1'b0);
	endtask : faults
	// keep bit is flipped mid-run; the value written at start must still decide
	task automatic run_selftest(input logic [DATA_W-1:0] v);
		wr(SUPPLY_SELFTEST_CONTROL_ADDR, v);
		tick(2);
		cmpb(o_selftest_running, 1'b1);
		rd(SUPPLY_SELFTEST_CONTROL_ADDR, v & 8'h02);
		wr(SUPPLY_SELFTEST_CONTROL_ADDR, v ^ 8'h02);
		@(posedge i_ref_clk);
		i_selftest_done <= 1'b1;
		@(posedge i_ref_clk);
		i_selftest_done <= 1'b0;
		tick(1);
		cmpb(o_selftest_running, 1'b0);
		cmpb(o_fault_out_n, !v[1]);
	endtask : run_selftest
	task automatic tally_and_finish;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish
	initial begin
		#200000;
		bad_count++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		tally_and_finish;
	end
	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		i_rst = 1'b1;
		{i_wr, i_rd, i_selftest_done} = 3'h0;
		i_clk_en = 1'b1;
		i_addr = 16'h0000;
		i_wdata = 8'h00;
		{i_supply_fault_a_set, i_supply_fault_b_set} = 16'h0000;
		{i_factory_crc_stored, i_factory_crc_calc, i_resp_crc} = 48'h0000_0000_0000;
		repeat (20) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		rd(OTP_DIAG_CONTROL_ADDR, OTP_DIAG_RESET);
		rd(COMM_DIAG_CONTROL_ADDR, COMM_DIAG_RESET);
		rd(SUPPLY_SELFTEST_CONTROL_ADDR, SUPPLY_DIAG_RESET);
		for (int k = 0; k < 24; k++) begin
			d = (k < 2) ? {8{k[0]}} : 8'($random(seed));
			s = 16'($random(seed));
			i_factory_crc_stored <= s;
			i_factory_crc_calc <= d[7] ? s : ~s;
			i_resp_crc <= 16'($random(seed));
			wr(OTP_DIAG_CONTROL_ADDR, d);
			wr(COMM_DIAG_CONTROL_ADDR, {6'h00, d[6:5]});
			tick(1);
			cmp(o_resp_crc, flip_of(d[5], i_resp_crc));
			cmp(o_factory_crc, flip_of(d[4], s));
			cmpb(o_factory_crc_fault, flip_of(d[4], s) != i_factory_crc_calc);
			cmp({12'h000, o_serial_master_loop_enable, o_margin_mode}, {12'h000, d[6], d[3:1]});
			rd(OTP_DIAG_CONTROL_ADDR, d & 8'h1e);
			rd(COMM_DIAG_CONTROL_ADDR, {6'h00, d[6:5]});
		end
		// a write taken while the clock enable is low must leave the register untouched
		i_clk_en <= 1'b0;
		wr(COMM_DIAG_CONTROL_ADDR, ~{6'h00, d[6:5]});
		i_clk_en <= 1'b1;
		rd(COMM_DIAG_CONTROL_ADDR, {6'h00, d[6:5]});
		rd(16'h0300, ZERO_BYTE);
		wr(EVENT_CLEAR_ADDR, 8'h07);
		wr(EVENT_STATUS_ADDR, 8'hff);
		rd(EVENT_STATUS_ADDR, ZERO_BYTE);
		faults(8'h01, 8'h00);
		run_selftest(8'h01);
		rd(SUPPLY_FAULT_A_ADDR, ZERO_BYTE);
		d = 8'($random(seed)) | 8'h01;
		faults(8'h00, d);
		run_selftest(8'h03);
		rd(SUPPLY_FAULT_B_ADDR, d);
		run_selftest(8'h01);
		rd(SUPPLY_FAULT_B_ADDR, ZERO_BYTE);
		wr(EVENT_ENABLE_ADDR, 8'h01);
		tick(1);
		cmpb(o_irq, 1'b1);
		rd(EVENT_STATUS_ADDR, 8'h05);
		wr(EVENT_ENABLE_ADDR, 8'h00);
		tick(1);
		cmpb(o_irq, 1'b0);
		wr(EVENT_ENABLE_ADDR, 8'h05);
		wr(EVENT_CLEAR_ADDR, 8'h01);
		tick(1);
		cmpb(o_irq, 1'b1);
		wr(EVENT_CLEAR_ADDR, 8'h04);
		tick(1);
		cmpb(o_irq, 1'b0);
		rd(EVENT_ENABLE_ADDR, 8'h05);
		tally_and_finish;
	end
endmodule : diagnostic_control_regs_tb
`default_nettype wire
